// ### rtl/sps_pin_select.sv
/*
 * Pin multiplexer for port B bits 7..4 and the routing matrix that places the UART,
 * synchronous serial and I2C channels, the timer A input and the shared interrupt
 * sources onto pins. Assumes port 2 and port 9 own their latches and pad drivers
 * elsewhere and take the function overrides given here; peripherals share the clock.
 */
`timescale 1ns/10ps
module sps_pin_select
	import sps_pkg::*;
(
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_arst_n,
	input  wire logic [sps_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [sps_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [sps_pkg::DATA_W-1:0]  o_rdata,
	input  wire logic [3:0]                  i_portb_latch,
	input  wire logic [3:0]                  i_portb_pin,
	output logic      [3:0]                  o_portb_out,
	output logic      [3:0]                  o_portb_oe,
	input  wire logic [5:0]                  i_port2_pin,
	output logic      [5:0]                  o_port2_fn_sel,
	output logic      [5:0]                  o_port2_fn_out,
	output logic      [5:0]                  o_port2_fn_oe,
	input  wire logic [1:0]                  i_port9_pin,
	output logic      [1:0]                  o_port9_fn_sel,
	output logic      [1:0]                  o_port9_fn_out,
	input  wire logic                        i_port7_bit2,
	input  wire logic                        i_uart_ch0_transmit,
	output logic                             o_uart_ch0_receive,
	input  wire logic                        i_uart_ch1_transmit,
	output logic                             o_uart_ch1_receive,
	input  wire logic                        i_sync_serial_data_out,
	input  wire logic                        i_sync_serial_clock_out,
	input  wire logic                        i_sync_serial_clock_oe,
	output logic                             o_sync_serial_data_in,
	output logic                             o_sync_serial_clock_in,
	input  wire logic                        i_i2c_sda_low,
	input  wire logic                        i_i2c_scl_low,
	output logic                             o_i2c_sda_in,
	output logic                             o_i2c_scl_in,
	output logic                             o_timer_a_input,
	input  wire logic                        i_uart_tx_irq,
	input  wire logic                        i_uart_rx_irq,
	input  wire logic                        i_sync_serial_irq,
	input  wire logic                        i_i2c_irq,
	output logic      [2:0]                  o_irq_src
);
	import sps_pkg::*;

	typedef struct packed {
		logic [3:0]       dir;
		logic [2:0]       fsel;
		logic [3:0]       otype;
		logic [1:0]       swap;
		sps_tsrc_t        tsrc;
		logic             grp;
		sps_pair_t        pair;
		logic [PAD_N-1:0] sy1;
		logic [PAD_N-1:0] sy2;
		logic [PAD_N-1:0] sy3;
		logic [PAD_N-1:0] pad;
		logic [7:0]       rdata;
		logic [3:0]       pb_out;
		logic [3:0]       pb_oe;
		logic [5:0]       p2_sel;
		logic [5:0]       p2_out;
		logic [5:0]       p2_oe;
		logic [1:0]       p9_sel;
		logic [1:0]       p9_out;
		logic             rx0;
		logic             rx1;
		logic             si;
		logic             sclk_in;
		logic             sda_in;
		logic             scl_in;
		logic             tmr;
		logic [2:0]       irq;
	} sps_state_t;

	sps_state_t s;
	sps_state_t next_s;

	always_comb
	begin
		logic             uart_on;
		logic             sio_grp;
		logic [2:0]       g_in;
		logic [2:0]       g_sel;
		logic [2:0]       g_out;
		logic [3:0]       fn_ok;
		logic [3:0]       fn_val;
		logic             d;
		logic [PAD_N-1:0] pads;
		uart_on = 1'b0;
		sio_grp = 1'b0;
		g_in    = 3'h0;
		g_sel   = 3'h0;
		g_out   = 3'h0;
		fn_ok   = 4'h0;
		fn_val  = 4'h0;
		d       = 1'b0;
		pads    = {i_port7_bit2, i_port9_pin, i_port2_pin, i_portb_pin};
		next_s  = s;

		// Pads are asynchronous; a level counts once the second and third stages agree.
		next_s.sy1 = pads;
		next_s.sy2 = s.sy1;
		next_s.sy3 = s.sy2;
		for (int k = 0; k < PAD_N; k++)
		begin
			if (s.sy2[k] == s.sy3[k])
				next_s.pad[k] = s.sy3[k];
		end

		if (i_wr)
		begin
			unique case (i_addr)
				OFS_PORTB_DIRECTION:
					next_s.dir = i_wdata[POS_PORTB_LO+3:POS_PORTB_LO];
				OFS_PORTB_FUNCTION_SELECT:
					next_s.fsel = i_wdata[POS_PORTB_LO+2:POS_PORTB_LO];
				OFS_PORTB_OUTPUT_TYPE:
					next_s.otype = i_wdata[POS_PORTB_LO+3:POS_PORTB_LO];
				OFS_UART_PIN_SWAP:
					next_s.swap = {i_wdata[POS_UART_CH1_SWAP], i_wdata[POS_UART_CH0_SWAP]};
				OFS_SERIAL_ROUTE_SELECT:
				begin
					next_s.pair = sps_pair_t'(i_wdata[POS_CHANNEL_PAIR+1:POS_CHANNEL_PAIR]);
					next_s.grp  = i_wdata[POS_PIN_GROUP];
					next_s.tsrc = sps_tsrc_t'(i_wdata[POS_TIMER_SOURCE+1:POS_TIMER_SOURCE]);
				end
				default:
				begin
				end
			endcase
		end

		if (i_rd)
		begin
			unique case (i_addr)
				OFS_PORTB_PIN_READBACK:
					next_s.rdata = {s.pad[PAD_PORTB+3:PAD_PORTB] & (~s.dir | s.otype), 4'h0};
				OFS_PORTB_DIRECTION:
					next_s.rdata = {s.dir, 4'h0};
				OFS_PORTB_FUNCTION_SELECT:
					next_s.rdata = {1'b0, s.fsel, 4'h0};
				OFS_PORTB_OUTPUT_TYPE:
					next_s.rdata = {s.otype, 4'h0};
				OFS_UART_PIN_SWAP:
					next_s.rdata = {6'h00, s.swap};
				OFS_SERIAL_ROUTE_SELECT:
					next_s.rdata = {s.tsrc, 1'b0, s.grp, 2'h0, s.pair};
				default:
					next_s.rdata = 8'h00;
			endcase
		end

		// Idle levels for inputs of channels that own no pin.
		next_s.rx0     = 1'b1;
		next_s.si      = 1'b1;
		next_s.sclk_in = 1'b1;
		next_s.sda_in  = 1'b1;
		next_s.scl_in  = 1'b1;
		next_s.p2_sel  = 6'h00;
		next_s.p2_out  = 6'h00;
		next_s.p2_oe   = 6'h00;

		g_in    = s.grp ? s.pad[PAD_PORTB+2:PAD_PORTB] : s.pad[PAD_PORT2+2:PAD_PORT2];
		uart_on = (s.pair == PAIR_UART_I2C) || (s.pair == PAIR_UART_SIO);
		sio_grp = (s.pair == PAIR_SIO_I2C);

		if (uart_on)
		begin
			// Swap 0 puts transmit on the first pin and receive on the second.
			g_sel[s.swap[0]]  = 1'b1;
			g_out[s.swap[0]]  = i_uart_ch0_transmit;
			next_s.rx0        = g_in[~s.swap[0]];
		end
		else if (sio_grp)
		begin
			g_sel          = {i_sync_serial_clock_oe, 1'b0, 1'b1};
			g_out          = {i_sync_serial_clock_out, 1'b0, i_sync_serial_data_out};
			next_s.si      = g_in[1];
			next_s.sclk_in = g_in[2];
		end

		if (s.grp)
		begin
			fn_ok[2:0]  = g_sel;
			fn_val[2:0] = g_out;
		end
		else
		begin
			next_s.p2_sel[2:0] = g_sel;
			next_s.p2_out[2:0] = g_out;
			next_s.p2_oe[2:0]  = g_sel;
		end

		if ((s.pair == PAIR_UART_I2C) || (s.pair == PAIR_SIO_I2C))
		begin
			// The I2C pins only ever pull low and otherwise release the line.
			next_s.p2_sel[4:3] = 2'h3;
			next_s.p2_out[4:3] = 2'h0;
			next_s.p2_oe[4:3]  = {i_i2c_scl_low, i_i2c_sda_low};
			next_s.sda_in      = s.pad[PAD_PORT2+3];
			next_s.scl_in      = s.pad[PAD_PORT2+4];
		end
		else if (s.pair == PAIR_UART_SIO)
		begin
			next_s.p2_sel[5:3] = {i_sync_serial_clock_oe, 1'b0, 1'b1};
			next_s.p2_out[5:3] = {i_sync_serial_clock_out, 1'b0, i_sync_serial_data_out};
			next_s.p2_oe[5:3]  = {i_sync_serial_clock_oe, 1'b0, 1'b1};
			next_s.si          = s.pad[PAD_PORT2+4];
			next_s.sclk_in     = s.pad[PAD_PORT2+5];
		end

		for (int b = 0; b < 4; b++)
		begin
			d = (b < 3) && s.fsel[b % 3] && fn_ok[b] ? fn_val[b] : i_portb_latch[b];
			next_s.pb_out[b] = s.otype[b] ? 1'b0 : d;
			next_s.pb_oe[b]  = s.dir[b] & (~s.otype[b] | ~d);
		end

		next_s.p9_sel = 2'h1 << s.swap[1];
		next_s.p9_out = {2{i_uart_ch1_transmit}};
		next_s.rx1    = s.pad[PAD_PORT9 + {31'h0, ~s.swap[1]}];

		unique case (s.tsrc)
			TSRC_PORT7_BIT2: next_s.tmr = s.pad[PAD_PORT7_2];
			TSRC_UART_CH0:   next_s.tmr = s.pad[PAD_PORT2+1];
			TSRC_UART_CH1:   next_s.tmr = s.pad[PAD_PORT9+1];
			TSRC_RSVD:       next_s.tmr = 1'b0;
		endcase

		unique case (s.pair)
			PAIR_UART_I2C: next_s.irq = {i_i2c_irq, i_uart_rx_irq, i_uart_tx_irq};
			PAIR_UART_SIO: next_s.irq = {i_sync_serial_irq, i_uart_rx_irq, i_uart_tx_irq};
			PAIR_SIO_I2C:  next_s.irq = {i_i2c_irq, i_sync_serial_irq, 1'b0};
			PAIR_RSVD:     next_s.irq = 3'h0;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s       <= '0;
			s.dir   <= RST_PORTB_DIRECTION;
			s.fsel  <= RST_PORTB_FUNCTION_SELECT;
			s.otype <= RST_PORTB_OUTPUT_TYPE;
			s.swap  <= RST_UART_PIN_SWAP;
			s.grp   <= RST_PIN_GROUP;
			s.pair  <= PAIR_UART_I2C;
			s.tsrc  <= TSRC_PORT7_BIT2;
			s.rx0   <= 1'b1;
			s.rx1   <= 1'b1;
			s.si    <= 1'b1;
			s.sclk_in <= 1'b1;
			s.sda_in  <= 1'b1;
			s.scl_in  <= 1'b1;
			s.p9_sel  <= 2'h1;
		end
		else
			s <= next_s;
	end

	assign o_rdata                = s.rdata;
	assign o_portb_out            = s.pb_out;
	assign o_portb_oe             = s.pb_oe;
	assign o_port2_fn_sel         = s.p2_sel;
	assign o_port2_fn_out         = s.p2_out;
	assign o_port2_fn_oe          = s.p2_oe;
	assign o_port9_fn_sel         = s.p9_sel;
	assign o_port9_fn_out         = s.p9_out;
	assign o_uart_ch0_receive     = s.rx0;
	assign o_uart_ch1_receive     = s.rx1;
	assign o_sync_serial_data_in  = s.si;
	assign o_sync_serial_clock_in = s.sclk_in;
	assign o_i2c_sda_in           = s.sda_in;
	assign o_i2c_scl_in           = s.scl_in;
	assign o_timer_a_input        = s.tmr;
	assign o_irq_src              = s.irq;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	dir_input_a: assert property ((o_portb_oe & ~$past(s.dir)) == 4'h0)
		else $error("Port B pin driven while its direction is input");
	open_drain_a: assert property ((o_portb_out & $past(s.otype)) == 4'h0)
		else $error("Open-drain port B pin driven high");
	readback_a: assert property ((i_rd && i_addr == OFS_PORTB_PIN_READBACK)
		|=> ((o_rdata[7:4] & $past(s.dir & ~s.otype)) == 4'h0 && o_rdata[3:0] == 4'h0))
		else $error("Push-pull output pin read back as one");
	sio_i2c_irq_a: assert property (($past(s.pair) == PAIR_SIO_I2C)
		|-> (!o_irq_src[0] && o_irq_src[1] == $past(i_sync_serial_irq)))
		else $error("Interrupt sources wrong for sync serial and I2C pairing");
	uart_i2c_irq_a: assert property (($past(s.pair) == PAIR_UART_I2C)
		|-> (o_irq_src == $past({i_i2c_irq, i_uart_rx_irq, i_uart_tx_irq})))
		else $error("Interrupt sources wrong for UART and I2C pairing");
	timer_src_a: assert property (($past(s.tsrc) == TSRC_UART_CH1)
		|-> (o_timer_a_input == $past(s.pad[PAD_PORT9+1])))
		else $error("Timer input not taken from port 9 bit 1");
	// The reset level of the receive output differs from the cleared pad stage, so the
	// first edge after release is left out.
	uart_channel_one_swap_a: assert property (($past(i_arst_n) && !$past(s.swap[1]))
		|-> (o_uart_ch1_receive == $past(s.pad[PAD_PORT9+1]) && o_port9_fn_sel == 2'h1))
		else $error("UART one pins not in unswapped place");
	group_pb_a: assert property ($past(s.grp) |-> (o_port2_fn_sel[2:0] == 3'h0))
		else $error("Port 2 low pins claimed while port B group selected");
	reserved_a: assert property (($past(s.pair) == PAIR_RSVD)
		|-> (o_port2_fn_sel == 6'h00 && o_irq_src == 3'h0))
		else $error("Reserved pairing routed a function");
	uart_channel_zero_swap_a: assert property (($past(s.pair) == PAIR_UART_I2C && !$past(s.grp)
		&& $past(s.swap[0])) |-> (o_port2_fn_sel[2:0] == 3'h2
		&& o_uart_ch0_receive == $past(s.pad[PAD_PORT2])))
		else $error("UART zero swap not applied on port 2 group");

endmodule // sps_pin_select

// ### rtl/sps_pkg.sv
/*
 * Constants for the serial port pin select block: register offsets, field positions,
 * reset values, channel pairing and timer source codes, and pad sample positions.
 * Assumes an 8-bit CPU register port with 12-bit addresses on the system clock.
 */
// Function
// - Port B direction bit: 0 input, 1 drive
// - Function bit hands pin to serial output
// - Output type: push-pull or open-drain low only
// - Readback gives pin unless push-pull output
// - Exactly two of three serial channels active
// - Pair code selects which two channels
// - Group bit moves UART/sync serial pins
// - Timer input source selected by two bits
// - UART one swap exchanges port 9 pins
// - UART zero swap exchanges group pins
// - Sync serial on group, swap ignored
// - Shared interrupt sources follow pair code
// - Unclaimed pins stay plain port bits
package sps_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	localparam logic [11:0] OFS_PORTB_PIN_READBACK    = 12'h018;
	localparam logic [11:0] OFS_PORTB_DIRECTION       = 12'hF25;
	localparam logic [11:0] OFS_PORTB_FUNCTION_SELECT = 12'hF3F;
	localparam logic [11:0] OFS_PORTB_OUTPUT_TYPE     = 12'hF4C;
	localparam logic [11:0] OFS_UART_PIN_SWAP         = 12'hF57;
	localparam logic [11:0] OFS_SERIAL_ROUTE_SELECT   = 12'hFCB;

	localparam int POS_PORTB_LO      = 4;
	localparam int POS_CHANNEL_PAIR  = 0;
	localparam int POS_PIN_GROUP     = 4;
	localparam int POS_TIMER_SOURCE  = 6;
	localparam int POS_UART_CH0_SWAP = 0;
	localparam int POS_UART_CH1_SWAP = 1;

	localparam logic [3:0] RST_PORTB_DIRECTION       = 4'h0;
	localparam logic [2:0] RST_PORTB_FUNCTION_SELECT = 3'h0;
	localparam logic [3:0] RST_PORTB_OUTPUT_TYPE     = 4'h0;
	localparam logic [1:0] RST_UART_PIN_SWAP         = 2'h0;
	localparam logic       RST_PIN_GROUP             = 1'b0;

	typedef enum logic [1:0] {
		PAIR_UART_I2C = 2'h0,
		PAIR_UART_SIO = 2'h1,
		PAIR_SIO_I2C  = 2'h2,
		PAIR_RSVD     = 2'h3
	} sps_pair_t;

	typedef enum logic [1:0] {
		TSRC_PORT7_BIT2 = 2'h0,
		TSRC_UART_CH0   = 2'h1,
		TSRC_UART_CH1   = 2'h2,
		TSRC_RSVD       = 2'h3
	} sps_tsrc_t;

	localparam int PAD_N       = 13;
	localparam int PAD_PORTB   = 0;
	localparam int PAD_PORT2   = 4;
	localparam int PAD_PORT9   = 10;
	localparam int PAD_PORT7_2 = 12;

endpackage

// ### sim/serial_port_pin_select_tb.sv
/*
 * Self-checking bench for the serial port pin select block.
 * Assumes the peripheral model in sps_periph_model.sv and the package sps_pkg.
 */
`timescale 1ns/10ps
module serial_port_pin_select_tb;
	import sps_pkg::*;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, run = 0, p7 = 0;
	logic [11:0] addr = 0;
	logic [7:0]  wd = 0, rdata;
	logic [3:0]  latch = 4'hF, pbpin = 4'hF, pbout, pboe, irq_req = 0, irq;
	logic [5:0]  p2pin = 6'h3F, p2sel, p2out, p2oe;
	logic [1:0]  p9pin = 2'h3, p9sel, p9out;
	logic        tx, sclk_oe, i2c_low, rx0, rx1, sdi, sclki, sda, scl, tmr;
	logic [2:0]  src;
	int          errors = 0, n_tests = 0;
	localparam logic [2:0] IRQ_EXP [3][4] = '{'{3'h1, 3'h2, 3'h0, 3'h4},
		'{3'h1, 3'h2, 3'h4, 3'h0}, '{3'h0, 3'h0, 3'h2, 3'h4}};
	always #2.5 clk = !clk;
	sps_periph_model pm (.i_clk_sys(clk), .i_run(run), .i_irq_req(irq_req), .o_tx(tx),
		.o_sclk_oe(sclk_oe), .o_i2c_low(i2c_low), .o_irq(irq));
	sps_pin_select uut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wd),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_portb_latch(latch), .i_portb_pin(pbpin),
		.o_portb_out(pbout), .o_portb_oe(pboe), .i_port2_pin(p2pin), .o_port2_fn_sel(p2sel),
		.o_port2_fn_out(p2out), .o_port2_fn_oe(p2oe), .i_port9_pin(p9pin),
		.o_port9_fn_sel(p9sel), .o_port9_fn_out(p9out), .i_port7_bit2(p7),
		.i_uart_ch0_transmit(tx), .o_uart_ch0_receive(rx0), .i_uart_ch1_transmit(tx),
		.o_uart_ch1_receive(rx1), .i_sync_serial_data_out(tx), .i_sync_serial_clock_out(tx),
		.i_sync_serial_clock_oe(sclk_oe), .o_sync_serial_data_in(sdi),
		.o_sync_serial_clock_in(sclki), .i_i2c_sda_low(i2c_low), .i_i2c_scl_low(i2c_low),
		.o_i2c_sda_in(sda), .o_i2c_scl_in(scl), .o_timer_a_input(tmr),
		.i_uart_tx_irq(irq[0]), .i_uart_rx_irq(irq[1]), .i_sync_serial_irq(irq[2]),
		.i_i2c_irq(irq[3]), .o_irq_src(src));
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		wr   <= 1;
		@(posedge clk);
		wr <= 0;
		cyc(3);
	endtask
	task automatic rd_chk(logic [11:0] a, logic [7:0] e, string nm);
		@(posedge clk);
		addr <= a;
		rd   <= 1;
		@(posedge clk);
		rd <= 0;
		cyc(2);
		chk(nm, e, rdata);
	endtask
	task automatic end_sim;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Reset values, reserved bits and an unmapped address.
	task automatic t_regs;
		rd_chk(OFS_PORTB_DIRECTION, 8'h00, "dir rst");
		chk("oe rst", 8'h00, pboe);
		rd_chk(OFS_PORTB_FUNCTION_SELECT, 8'h00, "fn rst");
		rd_chk(OFS_PORTB_OUTPUT_TYPE, 8'h00, "type rst");
		wr_reg(OFS_PORTB_DIRECTION, 8'hFF);
		rd_chk(OFS_PORTB_DIRECTION, 8'hF0, "dir rsvd");
		wr_reg(OFS_PORTB_FUNCTION_SELECT, 8'hFF);
		rd_chk(OFS_PORTB_FUNCTION_SELECT, 8'h70, "fn rsvd");
		wr_reg(OFS_SERIAL_ROUTE_SELECT, 8'hFF);
		rd_chk(OFS_SERIAL_ROUTE_SELECT, 8'hD3, "route rsvd");
		wr_reg(OFS_UART_PIN_SWAP, 8'hFF);
		rd_chk(OFS_UART_PIN_SWAP, 8'h03, "swap rsvd");
		wr_reg(12'h123, 8'hFF);
		rd_chk(12'h123, 8'h00, "unmapped");
	endtask
	// Reserved pairing leaves port B under its latch; push-pull and open-drain readback.
	task automatic t_port;
		latch <= 4'hA;
		pbpin <= 4'h5;
		cyc(6);
		chk("pp out", 8'h0A, pbout);
		chk("pp oe", 8'h0F, pboe);
		rd_chk(OFS_PORTB_PIN_READBACK, 8'h00, "pp read");
		wr_reg(OFS_PORTB_OUTPUT_TYPE, 8'hC0);
		chk("od out", 8'h02, pbout);
		chk("od oe", 8'h07, pboe);
		rd_chk(OFS_PORTB_PIN_READBACK, 8'h40, "od read");
		wr_reg(OFS_PORTB_DIRECTION, 8'h00);
		chk("in oe", 8'h00, pboe);
		rd_chk(OFS_PORTB_PIN_READBACK, 8'h50, "in read");
	endtask
	// Every pairing and pin group, with both swap bits clear and both set; interrupt sharing is checked for all but the reserved pairing.
	task automatic t_route;
		int t, r;
		wr_reg(OFS_PORTB_DIRECTION, 8'hF0);
		wr_reg(OFS_PORTB_OUTPUT_TYPE, 8'h00);
		latch <= 4'hF;
		for (int p = 0; p < 4; p++)
			for (int g = 0; g < 2; g++)
				for (int s = 0; s < 2; s++)
				begin
					run <= 0;
					wr_reg(OFS_SERIAL_ROUTE_SELECT, 8'(p) | 8'(g << 4));
					wr_reg(OFS_UART_PIN_SWAP, 8'(s * 3));
					t = (p == 2) ? 0 : s;
					r = 1 - t;
					run   <= 1;
					p2pin <= (g ? 6'h3F : ~(6'h01 << r)) & 6'h2F;
					pbpin <= g ? ~(4'h1 << r) : 4'hF;
					p9pin <= s ? 2'h2 : 2'h1;
					cyc(6);
					chk("pb7", 8'h01, pbout[3]);
					if (p == 3)
					begin
						chk("rsvd p2", 8'h00, p2sel);
						chk("rsvd pb", 8'h0F, pbout);
						chk("rsvd rx", 8'h01, rx0 & sdi & scl);
						continue;
					end
					chk("rx", 8'h00, (p == 2) ? sdi : rx0);
					if (g)
					begin
						chk("pb tx", 8'h00, pbout[t]);
						chk("p2 free", 8'h00, p2sel[2:0]);
					end
					else
					begin
						chk("p2 tx", 8'h04, {p2sel[t], p2out[t], p2sel[r]});
						chk("pb free", 8'h0F, pbout);
					end
					if (p == 1)
					begin
						chk("sio p23", 8'h02, {p2sel[3], p2out[3]});
						chk("sio p24", 8'h01, {sdi, sclki});
					end
					else
					begin
						chk("i2c p23", 8'h01, p2oe[3]);
						chk("i2c in", 8'h02, {sda, scl});
					end
					chk("u1 rx", 8'h00, rx1);
					chk("u1 tx", 8'h00, p9out);
					chk("u1 sel", s ? 8'h02 : 8'h01, p9sel);
					// Each interrupt request is raised alone once the new pairing has settled, and its attribution checked.
					for (int k = 0; k < 4; k++)
					begin
						@(posedge clk);
						irq_req <= 4'h1 << k;
						@(posedge clk);
						irq_req <= 4'h0;
						cyc(1);
						chk("irq", IRQ_EXP[p][k], src);
					end
				end
	endtask
	// Each timer source code, with the selected pad the only one that disagrees.
	task automatic t_timer;
		for (int c = 0; c < 4; c++)
		begin
			run <= 0;
			wr_reg(OFS_SERIAL_ROUTE_SELECT, 8'(c << 6));
			p7    <= (c == 0 || c == 3);
			p2pin <= (c == 1 || c == 3) ? 6'h3F : 6'h3D;
			p9pin <= (c >= 2) ? 2'h3 : 2'h1;
			cyc(6);
			chk("timer", (c != 3) ? 8'h01 : 8'h00, tmr);
		end
	endtask
	initial
	begin
		cyc(16);
		@(posedge clk);
		rst_n <= 1;
		cyc(2);
		t_regs();
		t_port();
		t_route();
		t_timer();
		end_sim();
	end
	initial
	begin
		#300000;
		errors++;
		end_sim();
	end
endmodule // serial_port_pin_select_tb

// ### sim/sps_periph_model.sv
/*
 * Behavioural model of the serial peripherals behind the pin select block.
 * Assumes the bench holds i_run low while it rewrites the routing registers.
 */
`timescale 1ns/10ps
module sps_periph_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_run,
	input  wire logic [3:0] i_irq_req,
	output logic            o_tx,
	output logic            o_sclk_oe,
	output logic            o_i2c_low,
	output logic [3:0]      o_irq
);
	// Stopped channels idle high and raise no interrupt, so a routing change sees no traffic.
	assign o_tx      = !i_run;
	assign o_sclk_oe = i_run;
	assign o_i2c_low = i_run;
	always_ff @(posedge i_clk_sys)
	begin
		o_irq <= i_run ? i_irq_req : 4'h0;
	end
endmodule // sps_periph_model
